// >>> pss_operand_model.sv
// far-side logic operands: pulsed inputs and the 3-bit word
`timescale 1ns/100ps
module pss_operand_model #(
	parameter int WIDTH = 20
) (
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic [2:0] press,
	input  wire logic [2:0] word_value,
	output logic      [2:0] pulse_out,
	output logic      [2:0] word_out
);
	logic [7:0] cnt_ff [3];

	// operands change only on the clock, like logic equation results
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < 3; i++) begin
			if (reset)
				cnt_ff[i] <= 8'h00;
			else if (press[i])
				cnt_ff[i] <= 8'(WIDTH);
			else if (cnt_ff[i] != 8'h00)
				cnt_ff[i] <= cnt_ff[i] - 8'h01;
		end
		word_out <= word_value;
	end
	assign pulse_out = {cnt_ff[2] != 8'h00, cnt_ff[1] != 8'h00,
		cnt_ff[0] != 8'h00};
endmodule

// >>> pss_pkg.sv
// shared constants, register map and state encoding of the selector switch
package pss_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS      = 10;
	localparam int TICK_PERIOD_NS     = 1000000;
	localparam int TICK_CYCLES_DEF    = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TENTH_S_NS         = 100000000;
	localparam int TICKS_PER_TENTH    = TENTH_S_NS / TICK_PERIOD_NS;
	localparam int ALARM_TIME_MS      = 3000;
	// widened on purpose: ms times ns per ms overflows a 32-bit int
	localparam int ALARM_TICKS        = int'(longint'(ALARM_TIME_MS)
		* 1000000 / TICK_PERIOD_NS);
	localparam int POWER_CYCLE_MS_DEF = 20;
	localparam int HOLD_POWER_CYCLES  = 2;
	localparam int TMR_W              = 16;
	localparam int ALM_W              = 12;

	// ****************************************************************
	// register map and fields
	// ****************************************************************
	localparam logic [7:0] REG_CONFIG  = 8'h00;
	localparam logic [7:0] REG_TIMEOUT = 8'h04;
	localparam logic [7:0] REG_STATUS  = 8'h08;

	localparam int CFG_RANGE_LSB  = 0;
	localparam int CFG_INC_ACK    = 4;
	localparam int CFG_WORD_ACK   = 5;
	localparam int CFG_PWR_LSB    = 6;
	localparam int TMO_LSB        = 0;
	localparam int ST_APPLIED_LSB = 0;
	localparam int ST_PRE_LSB     = 4;
	localparam int ST_INC_PEND    = 8;
	localparam int ST_WORD_PEND   = 9;
	localparam int ST_ALARM_LSB   = 10;
	localparam int ST_STARTUP     = 13;

	localparam logic [2:0] POS_REST      = 3'h0;
	localparam logic [2:0] POS_FIRST     = 3'h1;
	localparam logic [2:0] POS_LAST      = 3'h7;
	localparam logic [9:0] TIMEOUT_MIN   = 10'h01E;
	localparam logic [9:0] TIMEOUT_MAX   = 10'h258;
	localparam logic [9:0] TIMEOUT_RESET = 10'h032;

	localparam logic [1:0] PWR_RESTORE      = 2'h0;
	localparam logic [1:0] PWR_SYNC         = 2'h1;
	localparam logic [1:0] PWR_SYNC_RESTORE = 2'h2;

	localparam int ALM_RANGE = 0;
	localparam int ALM_INC   = 1;
	localparam int ALM_WORD  = 2;
	localparam int ALM_NUM   = 3;

	typedef enum logic [2:0] {
		PSS_POWERUP   = 3'b000,
		PSS_SYNC_HOLD = 3'b001,
		PSS_IDLE      = 3'b010,
		PSS_INC_PEND  = 3'b011,
		PSS_WORD_PEND = 3'b100
	} pss_state_t;

endpackage

// >>> pss_selector_properties.sv
// port assertions for the selector switch
`timescale 1ns/100ps
module pss_selector_checker import pss_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        nv_write_strobe,
	input wire logic [2:0]  nv_write_position,
	input wire logic [6:0]  position_onehot,
	input wire logic [2:0]  applied_position,
	input wire logic        in_use_indication,
	input wire logic        preselect_indication,
	input wire logic [2:0]  preselect_position,
	input wire logic        selector_alarm
);
	// two ticks of slack: the alarm starts off the tick grid
	localparam int ALM_LO = (ALARM_TICKS - 2) * TICK_CYCLES;
	localparam int ALM_HI = (ALARM_TICKS + 2) * TICK_CYCLES;
	logic [31:0] alm_cnt_ff;
	logic [31:0] nxt_alm_cnt;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);

	assign nxt_alm_cnt = selector_alarm ? alm_cnt_ff + 32'h1 : 32'h0;
	always_ff @(posedge ref_clk) begin
		alm_cnt_ff <= reset ? 32'h0 : nxt_alm_cnt;
	end

	sequence one_shot(sig);
		sig ##1 !sig;
	endsequence

	// ****************************************************************
	// assertions
	// ****************************************************************
	onehot_map_a: assert property (
		position_onehot == ((applied_position == 3'h0) ? 7'h00 :
		7'h01 << (applied_position - 3'h1)))
		else $error("one-hot output disagrees with binary position");
	rdata_idle_a: assert property (
		!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside read answer");
	use_pulse_a: assert property (
		$rose(in_use_indication) |-> one_shot(in_use_indication))
		else $error("in-use pulse longer than one cycle");
	pre_pulse_a: assert property (
		$rose(preselect_indication) |-> one_shot(preselect_indication))
		else $error("pre-select pulse longer than one cycle");
	nv_follow_a: assert property (
		nv_write_strobe == in_use_indication &&
		(!in_use_indication || nv_write_position == applied_position))
		else $error("stored position write does not follow apply");
	reset_quiet_a: assert property (
		$past(reset) |-> applied_position == 3'h0 && position_onehot == 7'h00)
		else $error("position outputs active right after reset");
	pre_valid_a: assert property (
		preselect_indication |-> preselect_position != 3'h0)
		else $error("pre-selected position zero on indication");
	alarm_len_a: assert property (
		$fell(selector_alarm) |-> alm_cnt_ff >= ALM_LO && alm_cnt_ff <= ALM_HI)
		else $error("range alarm length wrong");
endmodule

// >>> pss_selector_switch.sv
// selector switch: increment and word paths, apply timing, alarms, power-up
`timescale 1ns/100ps
// What this block does
// - top position configurable 1 to 7; positions run 1 to that maximum
// - stepping past the maximum wraps the pre-selection back to position 1
// - word above maximum: no change, general alarm for 3 seconds
// - time-out configurable 3.0 to 60.0 s in 0.1 s steps
// - increment time-out mode: apply after full time-out of inactivity
// - activity restarts timer; missing acknowledge discards change, raises alarm
// - each increment rising edge while idle or increment pending advances pre-selection by exactly one
// - increment edge restarts timer and flags pre-selection with its number
// - applying a position raises in-use indication with the applied number
// - increment acknowledge mode: no acknowledge in time gives 3 s alarm
// - increment acknowledge edge applies pending position only in acknowledge mode
// - word decoded binary, bit2 most significant; zero is rest
// - rest word causes no pre-selection and no position change
// - word time-out mode: apply after time-out since last word change
// - increment and word paths lock each other out while pending
// - applied position kept in storage; power-up restores or synchronises
// - restore of out-of-range stored value gives position 0 and alarm
// - synchronise: hold 0 with alarm two power cycles, then adopt word
// - synchronise-then-restore falls back to stored position on failure
module pss_selector_switch import pss_pkg::*; #(
	parameter int         TICK_CYCLES        = TICK_CYCLES_DEF,
	parameter int         POWER_CYCLE_MS     = POWER_CYCLE_MS_DEF,
	parameter logic [1:0] PWRUP_MODE_DEFAULT = PWR_RESTORE
) (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        increment_input,
	input  wire logic        increment_confirm_input,
	input  wire logic        position_word_bit0,
	input  wire logic        position_word_bit1,
	input  wire logic        position_word_bit2,
	input  wire logic        word_confirm_input,
	input  wire logic [2:0]  nv_stored_position,
	output logic             nv_write_strobe,
	output logic      [2:0]  nv_write_position,
	output logic      [6:0]  position_onehot,
	output logic      [2:0]  applied_position,
	output logic             in_use_indication,
	output logic             preselect_indication,
	output logic      [2:0]  preselect_position,
	output logic             selector_alarm,
	output logic             increment_path_alarm,
	output logic             word_path_alarm,
	output logic             startup_alarm
);
	localparam int SYNC_HOLD_TICKS = (HOLD_POWER_CYCLES * POWER_CYCLE_MS
		* 1000000 + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS;
	localparam logic [TMR_W-1:0] SYNC_HOLD = TMR_W'(SYNC_HOLD_TICKS);
	localparam logic [TMR_W-1:0] TENTH     = TMR_W'(TICKS_PER_TENTH);
	localparam logic [ALM_W-1:0] ALM_LOAD  = ALM_W'(ALARM_TICKS);

	if (POWER_CYCLE_MS < 1 || SYNC_HOLD_TICKS >= (1 << TMR_W)) begin : g_chk
		$error("power cycle length out of supported range");
	end

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic in_range(input logic [2:0] p,
		input logic [2:0] top);
		in_range = (p != POS_REST) && (p <= top);
	endfunction

	function automatic logic [6:0] onehot(input logic [2:0] p);
		onehot = (p == POS_REST) ? 7'h00 : 7'(7'h01 << (p - POS_FIRST));
	endfunction

	function automatic logic [2:0] step(input logic [2:0] p,
		input logic [2:0] top);
		step = (p == POS_REST || p >= top) ? POS_FIRST : p + POS_FIRST;
	endfunction

	// ****************************************************************
	// input synchronisers and edge detection
	// ****************************************************************
	logic [5:0] sync1_ff;
	logic [5:0] sync2_ff;
	logic [5:0] prev_ff;
	wire  [5:0] raw_in = {word_confirm_input, position_word_bit2,
		position_word_bit1, position_word_bit0,
		increment_confirm_input, increment_input};

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sync1_ff <= 6'h00;
			sync2_ff <= 6'h00;
			prev_ff  <= 6'h00;
		end else begin
			sync1_ff <= raw_in;
			sync2_ff <= sync1_ff;
			prev_ff  <= sync2_ff;
		end
	end

	wire [2:0] word_now    = sync2_ff[4:2];
	wire       inc_rise    = sync2_ff[0] & ~prev_ff[0];
	wire       inc_ack_rise = sync2_ff[1] & ~prev_ff[1];
	wire       word_ack_rise = sync2_ff[5] & ~prev_ff[5];
	// rest word counts as no activity at all
	wire       word_act = (word_now != prev_ff[4:2]) &&
		(word_now != POS_REST);

	// ****************************************************************
	// configuration registers
	// ****************************************************************
	logic [2:0] cfg_range_ff;
	logic [9:0] cfg_timeout_ff;
	logic       cfg_inc_ack_ff;
	logic       cfg_word_ack_ff;
	logic [1:0] cfg_pwr_ff;

	wire wr_cfg = reg_wr && (reg_addr == REG_CONFIG);
	wire wr_tmo = reg_wr && (reg_addr == REG_TIMEOUT);
	wire [2:0] wr_range = reg_wdata[CFG_RANGE_LSB +: 3];
	wire [9:0] wr_tmo_v = reg_wdata[TMO_LSB +: 10];
	// out-of-range writes are clamped, so the logic never sees 0
	wire [2:0] nxt_range = (wr_range == POS_REST) ? POS_FIRST :
		wr_range;
	wire [9:0] nxt_timeout = (wr_tmo_v < TIMEOUT_MIN) ? TIMEOUT_MIN :
		(wr_tmo_v > TIMEOUT_MAX) ? TIMEOUT_MAX : wr_tmo_v;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cfg_range_ff    <= POS_LAST;
			cfg_timeout_ff  <= TIMEOUT_RESET;
			cfg_inc_ack_ff  <= 1'b0;
			cfg_word_ack_ff <= 1'b0;
			cfg_pwr_ff      <= PWRUP_MODE_DEFAULT;
		end else begin
			if (wr_cfg) begin
				cfg_range_ff    <= nxt_range;
				cfg_inc_ack_ff  <= reg_wdata[CFG_INC_ACK];
				cfg_word_ack_ff <= reg_wdata[CFG_WORD_ACK];
				cfg_pwr_ff      <= reg_wdata[CFG_PWR_LSB +: 2];
			end
			if (wr_tmo)
				cfg_timeout_ff <= nxt_timeout;
		end
	end

	// ****************************************************************
	// tick and time-out timer
	// ****************************************************************
	logic             tick;
	logic [TMR_W-1:0] tmr_ff;
	logic             restart;

	pss_tick_gen #(
		.CYCLES (TICK_CYCLES)
	) u_tick (
		.ref_clk (ref_clk),
		.reset   (reset),
		.tick    (tick)
	);

	wire [TMR_W-1:0] tmo_limit = TMR_W'(cfg_timeout_ff) * TENTH;
	wire             expired   = (tmr_ff >= tmo_limit);
	wire             sync_done = (tmr_ff >= SYNC_HOLD);
	wire [TMR_W-1:0] nxt_tmr   = restart ? '0 :
		(tick && !(&tmr_ff)) ? tmr_ff + TMR_W'(1) : tmr_ff;

	// ****************************************************************
	// sequencing
	// ****************************************************************
	pss_state_t   state_ff;
	pss_state_t   nxt_state;
	logic [2:0]   pre_ff;
	logic [2:0]   nxt_pre;
	logic [2:0]   applied_ff;
	logic [2:0]   nxt_applied;
	logic         startup_ff;
	logic         nxt_startup;
	logic         do_apply;
	logic         pre_event;
	logic [ALM_NUM-1:0] alm_start;

	wire word_ok = in_range(word_now, cfg_range_ff);
	wire nv_ok   = in_range(nv_stored_position, cfg_range_ff);

	always_comb begin
		nxt_state   = state_ff;
		nxt_pre     = pre_ff;
		nxt_applied = applied_ff;
		nxt_startup = startup_ff;
		do_apply    = 1'b0;
		restart     = 1'b0;
		pre_event   = 1'b0;
		alm_start   = '0;
		case (state_ff)
		PSS_POWERUP: begin
			restart = 1'b1;
			if (cfg_pwr_ff == PWR_SYNC || cfg_pwr_ff == PWR_SYNC_RESTORE) begin
				nxt_applied = POS_REST;
				nxt_startup = 1'b1;
				nxt_state   = PSS_SYNC_HOLD;
			end else if (nv_ok) begin
				nxt_applied = nv_stored_position;
				do_apply    = 1'b1;
				nxt_state   = PSS_IDLE;
			end else begin
				nxt_applied = POS_REST;
				nxt_startup = 1'b1;
				nxt_state   = PSS_IDLE;
			end
		end
		PSS_SYNC_HOLD: begin
			if (sync_done) begin
				nxt_state = PSS_IDLE;
				if (word_ok) begin
					nxt_applied = word_now;
					do_apply    = 1'b1;
					nxt_startup = 1'b0;
				end else if (cfg_pwr_ff == PWR_SYNC_RESTORE && nv_ok) begin
					nxt_applied = nv_stored_position;
					do_apply    = 1'b1;
				end
			end
		end
		PSS_IDLE: begin
			if (inc_rise) begin
				nxt_pre   = step(applied_ff, cfg_range_ff);
				pre_event = 1'b1;
				restart   = 1'b1;
				nxt_state = PSS_INC_PEND;
			end else if (word_act) begin
				if (word_ok) begin
					nxt_pre   = word_now;
					restart   = 1'b1;
					nxt_state = PSS_WORD_PEND;
				end else begin
					alm_start[ALM_RANGE] = 1'b1;
				end
			end
		end
		PSS_INC_PEND: begin
			// word inputs are not looked at here
			if (inc_rise) begin
				nxt_pre   = step(pre_ff, cfg_range_ff);
				pre_event = 1'b1;
				restart   = 1'b1;
			end else if (cfg_inc_ack_ff) begin
				if (inc_ack_rise && !expired) begin
					do_apply  = 1'b1;
					nxt_state = PSS_IDLE;
				end else if (expired) begin
					alm_start[ALM_INC] = 1'b1;
					nxt_state = PSS_IDLE;
				end
			end else if (expired) begin
				do_apply  = 1'b1;
				nxt_state = PSS_IDLE;
			end
		end
		PSS_WORD_PEND: begin
			// increment edges are ignored while a word change is pending
			if (word_act) begin
				if (word_ok) begin
					nxt_pre = word_now;
					restart = 1'b1;
				end else begin
					alm_start[ALM_RANGE] = 1'b1;
				end
			end else if (cfg_word_ack_ff) begin
				if (word_ack_rise && !expired) begin
					do_apply  = 1'b1;
					nxt_state = PSS_IDLE;
				end else if (expired) begin
					alm_start[ALM_WORD] = 1'b1;
					nxt_state = PSS_IDLE;
				end
			end else if (expired) begin
				do_apply  = 1'b1;
				nxt_state = PSS_IDLE;
			end
		end
		default: begin
			nxt_state = PSS_POWERUP;
		end
		endcase
		if (do_apply && (state_ff == PSS_INC_PEND ||
			state_ff == PSS_WORD_PEND)) begin
			nxt_applied = pre_ff;
			nxt_startup = 1'b0;
		end
	end

	// ****************************************************************
	// alarm timers
	// ****************************************************************
	logic [ALM_W-1:0]   alm_cnt_ff [ALM_NUM];
	logic [ALM_W-1:0]   nxt_alm_cnt [ALM_NUM];
	logic [ALM_NUM-1:0] alarm_ff;

	for (genvar i = 0; i < ALM_NUM; i++) begin : g_alm
		// a new event simply restarts the full 3 s
		assign nxt_alm_cnt[i] = alm_start[i] ? ALM_LOAD :
			(tick && alm_cnt_ff[i] != '0) ? alm_cnt_ff[i] - ALM_W'(1) :
			alm_cnt_ff[i];
		always_ff @(posedge ref_clk) begin
			if (reset) begin
				alm_cnt_ff[i] <= '0;
				alarm_ff[i]   <= 1'b0;
			end else begin
				alm_cnt_ff[i] <= nxt_alm_cnt[i];
				alarm_ff[i]   <= (nxt_alm_cnt[i] != '0);
			end
		end
	end

	// ****************************************************************
	// state and output registers
	// ****************************************************************
	logic [6:0]  onehot_ff;
	logic        in_use_ff;
	logic        pre_ind_ff;
	logic        nv_wr_ff;
	logic [31:0] rdata_ff;

	wire [31:0] status_word = (32'(applied_ff) << ST_APPLIED_LSB) |
		(32'(pre_ff) << ST_PRE_LSB) |
		(32'(state_ff == PSS_INC_PEND) << ST_INC_PEND) |
		(32'(state_ff == PSS_WORD_PEND) << ST_WORD_PEND) |
		(32'(alarm_ff) << ST_ALARM_LSB) |
		(32'(startup_ff) << ST_STARTUP);
	wire [31:0] config_word = (32'(cfg_range_ff) << CFG_RANGE_LSB) |
		(32'(cfg_inc_ack_ff) << CFG_INC_ACK) |
		(32'(cfg_word_ack_ff) << CFG_WORD_ACK) |
		(32'(cfg_pwr_ff) << CFG_PWR_LSB);
	wire [31:0] rd_mux = (reg_addr == REG_CONFIG)  ? config_word :
		(reg_addr == REG_TIMEOUT) ? (32'(cfg_timeout_ff) << TMO_LSB) :
		(reg_addr == REG_STATUS)  ? status_word : 32'h00000000;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_ff   <= PSS_POWERUP;
			tmr_ff     <= '0;
			pre_ff     <= POS_REST;
			applied_ff <= POS_REST;
			startup_ff <= 1'b0;
			onehot_ff  <= 7'h00;
			in_use_ff  <= 1'b0;
			pre_ind_ff <= 1'b0;
			nv_wr_ff   <= 1'b0;
			rdata_ff   <= 32'h00000000;
		end else begin
			state_ff   <= nxt_state;
			tmr_ff     <= nxt_tmr;
			pre_ff     <= nxt_pre;
			applied_ff <= nxt_applied;
			startup_ff <= nxt_startup;
			onehot_ff  <= onehot(nxt_applied);
			in_use_ff  <= do_apply;
			pre_ind_ff <= pre_event;
			nv_wr_ff   <= do_apply;
			rdata_ff   <= reg_rd ? rd_mux : 32'h00000000;
		end
	end

	assign reg_rdata            = rdata_ff;
	assign nv_write_strobe      = nv_wr_ff;
	assign nv_write_position    = applied_ff;
	assign position_onehot      = onehot_ff;
	assign applied_position     = applied_ff;
	assign in_use_indication    = in_use_ff;
	assign preselect_indication = pre_ind_ff;
	assign preselect_position   = pre_ff;
	assign selector_alarm       = alarm_ff[ALM_RANGE];
	assign increment_path_alarm = alarm_ff[ALM_INC];
	assign word_path_alarm      = alarm_ff[ALM_WORD];
	assign startup_alarm        = startup_ff;
endmodule

// >>> pss_selector_switch_bench.sv
// self-checking bench for the selector switch
`timescale 1ns/100ps
module pss_selector_switch_bench
import pss_pkg::*;
;
	localparam int TCK = 5;
	localparam int TO_CYC = int'(TIMEOUT_MIN) * TICKS_PER_TENTH * TCK;
	localparam int SYNC_WAIT = HOLD_POWER_CYCLES * POWER_CYCLE_MS_DEF
		* 1000000 / TICK_PERIOD_NS * TCK + 20;
	logic        ref_clk, reset, reg_wr, reg_rd;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv;
	logic [2:0]  press, word_value, pulse_out, word_out, nv_stored_position;
	logic [2:0]  nv_write_position, applied_position, preselect_position;
	logic [6:0]  position_onehot;
	logic        nv_write_strobe, in_use_indication, preselect_indication;
	logic        selector_alarm, increment_path_alarm, word_path_alarm;
	logic        startup_alarm, sync_alarm;
	logic [2:0]  sync_position;
	int          num_errors, checks, n;

	pss_selector_switch #(.TICK_CYCLES(TCK)) u_pss_selector_switch (
		.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .increment_input(pulse_out[0]),
		.increment_confirm_input(pulse_out[1]),
		.position_word_bit0(word_out[0]), .position_word_bit1(word_out[1]),
		.position_word_bit2(word_out[2]), .word_confirm_input(pulse_out[2]),
		.nv_stored_position, .nv_write_strobe, .nv_write_position,
		.position_onehot, .applied_position, .in_use_indication,
		.preselect_indication, .preselect_position, .selector_alarm,
		.increment_path_alarm, .word_path_alarm, .startup_alarm);
	pss_operand_model u_pss_operand_model (.ref_clk, .reset, .press,
		.word_value, .pulse_out, .word_out);
	// second copy strapped to synchronise-then-restore at power-up
	pss_selector_switch #(.TICK_CYCLES(TCK),
		.PWRUP_MODE_DEFAULT(PWR_SYNC_RESTORE)) u_pss_selector_switch_sync (
		.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata(), .increment_input(pulse_out[0]),
		.increment_confirm_input(pulse_out[1]),
		.position_word_bit0(word_out[0]), .position_word_bit1(word_out[1]),
		.position_word_bit2(word_out[2]), .word_confirm_input(pulse_out[2]),
		.nv_stored_position, .nv_write_strobe(), .nv_write_position(),
		.position_onehot(), .applied_position(sync_position),
		.in_use_indication(), .preselect_indication(),
		.preselect_position(), .selector_alarm(), .increment_path_alarm(),
		.word_path_alarm(), .startup_alarm(sync_alarm));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task check(input string what, input logic [31:0] exp, got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task tick(input int c);
		repeat (c) @(posedge ref_clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// increment pulses keep the source's minimum spacing
	task push(input int i);
		if (i == 0) tick(600);
		@(posedge ref_clk);
		press[i] <= 1'b1;
		@(posedge ref_clk);
		press[i] <= 1'b0;
		tick(30);
	endtask
	task wait_for(input int sel, input int lim, output int c);
		c = 0;
		while (!(sel == 2 ? word_path_alarm === 1'b1 :
			sel == 1 ? increment_path_alarm === 1'b1 :
			in_use_indication === 1'b1) && c < lim) begin
			tick(1);
			c++;
		end
		if (c >= lim) begin
			num_errors++;
			$display("wrong value wait expected event seen none");
			print_verdict();
		end
	endtask
	task do_reset(input logic [2:0] nv);
		@(posedge ref_clk);
		nv_stored_position <= nv;
		reset <= 1'b1;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		tick(4);
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task t_powerup;
		do_reset(3'h0);
		check("startup_alarm", 1, startup_alarm);
		check("applied", 0, applied_position);
		do_reset(3'h3);
		check("applied", 3, applied_position);
		check("onehot", 7'h04, position_onehot);
		$display("test powerup done");
	endtask
	task t_regs;
		rd(REG_CONFIG, rv);
		check("config", 32'h07, rv);
		rd(REG_TIMEOUT, rv);
		check("timeout", 32'h032, rv);
		rd(8'h0C, rv);
		check("unmapped", 0, rv);
		wr(REG_TIMEOUT, 32'h0A);
		rd(REG_TIMEOUT, rv);
		check("timeout", 32'h01E, rv);
		$display("test registers done");
	endtask
	task t_step_ack;
		wr(REG_CONFIG, 32'h14);
		push(0);
		check("preselect", 4, preselect_position);
		push(0);
		check("preselect", 1, preselect_position);
		push(1);
		check("applied", 1, applied_position);
		check("onehot", 7'h01, position_onehot);
		$display("test step acknowledge done");
	endtask
	task t_word;
		wr(REG_CONFIG, 32'h34);
		word_value <= 3'h5;
		tick(20);
		check("selector_alarm", 1, selector_alarm);
		check("applied", 1, applied_position);
		word_value <= 3'h0;
		tick(20);
		check("applied", 1, applied_position);
		word_value <= 3'h2;
		tick(20);
		check("preselect", 2, preselect_position);
		push(0);
		check("preselect", 2, preselect_position);
		push(2);
		check("applied", 2, applied_position);
		$display("test word done");
	endtask
	task t_timeout;
		wr(REG_CONFIG, 32'h04);
		push(0);
		check("preselect", 3, preselect_position);
		push(1);
		wait_for(1'b0, 31000, n);
		check("applied", 3, applied_position);
		check("delay ok", 1, n >= TO_CYC - 200 && n <= TO_CYC + 50);
		$display("test time-out done");
	endtask
	task t_expire;
		wr(REG_CONFIG, 32'h14);
		push(0);
		check("preselect", 4, preselect_position);
		wait_for(1'b1, 31000, n);
		check("applied", 3, applied_position);
		$display("test expiry done");
	endtask
	task t_word_tmo;
		wr(REG_CONFIG, 32'h04);
		word_value <= 3'h4;
		wait_for(0, 31000, n);
		check("applied", 4, applied_position);
		wr(REG_CONFIG, 32'h24);
		word_value <= 3'h1;
		wait_for(2, 31000, n);
		check("word alarm", 1, word_path_alarm);
		check("applied", 4, applied_position);
		rd(REG_STATUS, rv);
		check("status", 32'h1014, rv);
		$display("test word time-out done");
	endtask
	task t_sync;
		@(posedge ref_clk);
		word_value <= 3'h0;
		do_reset(3'h3);
		check("sync applied", 0, sync_position);
		check("sync alarm", 1, sync_alarm);
		tick(SYNC_WAIT);
		check("sync applied", 3, sync_position);
		check("sync alarm", 1, sync_alarm);
		@(posedge ref_clk);
		word_value <= 3'h2;
		do_reset(3'h3);
		tick(SYNC_WAIT);
		check("sync applied", 2, sync_position);
		check("sync alarm", 0, sync_alarm);
		$display("test synchronise done");
	endtask

	initial begin
		reset = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		press = 3'h0;
		word_value = 3'h0;
		nv_stored_position = 3'h0;
		num_errors = 0;
		checks = 0;
		t_powerup();
		t_regs();
		t_step_ack();
		t_word();
		t_timeout();
		t_expire();
		t_word_tmo();
		t_sync();
		print_verdict();
	end
endmodule

bind pss_selector_switch pss_selector_checker #(.TICK_CYCLES(TICK_CYCLES))
	u_pss_selector_checker (.ref_clk, .reset, .reg_rd, .reg_rdata,
	.nv_write_strobe, .nv_write_position, .position_onehot,
	.applied_position, .in_use_indication, .preselect_indication,
	.preselect_position, .selector_alarm);

// >>> pss_tick_gen.sv
// fixed periodic tick derived from the system clock
`timescale 1ns/100ps
module pss_tick_gen #(
	parameter int CYCLES = 100000
) (
	input  wire logic ref_clk,
	input  wire logic reset,
	output logic      tick
);
	localparam int CW = $clog2(CYCLES);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] cnt_ff;
	logic          tick_ff;
	wire           wrap = (cnt_ff == LAST);
	wire  [CW-1:0] nxt_cnt = wrap ? '0 : cnt_ff + CW'(1);

	if (CYCLES < 2) begin : g_chk
		$error("tick period must span at least two clocks");
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cnt_ff  <= '0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			tick_ff <= wrap;
		end
	end

	assign tick = tick_ff;
endmodule
